// ===== sim/usb_control_endpoint_setup_tb.sv
module usb_control_endpoint_setup_tb import usb_ep0_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [31:0] rdata;
    logic        irq, usb_pll_enable, tok_valid, tok_busy, rx_valid, suspend_det;
    logic        hs_valid, hs_nak, tx_valid, tx_last, tx_ready;
    logic [1:0]  tok_kind;
    logic [3:0]  tok_ep;
    logic [7:0]  rx_data, tx_data;
    logic [7:0]  sb[8] = '{8'h80, 8'h06, 8'h00, 8'h01, 8'h00, 8'h00, 8'h08, 8'h00};
    logic [7:0]  exp_q[$];
    logic [15:0] c;
    int          err_total = 0;
    int          compares = 0;

    always #5 clock = ~clock;

    usb_ep0_ctrl i_dut (.clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .irq,
        .usb_pll_enable, .tok_valid, .tok_kind, .tok_ep, .tok_busy, .rx_valid,
        .rx_data, .suspend_det, .hs_valid, .hs_nak, .tx_valid, .tx_data, .tx_last,
        .tx_ready);
    usb_host_model host (.clock, .tok_valid, .tok_kind, .tok_ep, .tok_busy,
        .rx_valid, .rx_data, .suspend_det, .tx_ready, .hs_valid, .hs_nak,
        .tx_valid, .tx_data, .tx_last);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
        // one idle edge so a following write never re-raises wr in this time step
        @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(rdata, exp, what);
        @(posedge clock);
    endtask

    task automatic ep_en(input logic e);
        wr_reg(REG_IN_CFG, {24'h0, e, 7'h0});
        wr_reg(REG_OUT_CFG, {24'h0, e, 7'h0});
    endtask

    task automatic wait_bytes(input int n);
        int k;
        for (k = 0; k < 300 && host.got.size() < n; k++) @(posedge clock);
        if (k == 300) begin
            err_total++;
            give_verdict();
        end
    endtask

    // compares what the host took against exp_q, then empties the capture
    task automatic cmp_got();
        foreach (host.got[i]) check(32'(host.got[i]), 32'(exp_q[i]), "tx byte");
        host.got.delete();
    endtask

    function automatic logic [15:0] crc16(input logic [7:0] b[$]);
        logic [15:0] r;
        r = CRC_INIT;
        foreach (b[i]) begin
            r ^= 16'(b[i]);
            repeat (8) r = r[0] ? (r >> 1) ^ CRC_POLY : r >> 1;
        end
        return ~r;
    endfunction

    initial begin
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        rd_chk(REG_CTRL, 32'h0, "ctrl reset");
        rd_chk(8'hF0, 32'h0, "unmapped");
        wr_reg(REG_CTRL, 32'h3);
        wr_reg(REG_IE, 32'h7);
        ep_en(1'b1);
        host.setup(sb);
        repeat (2) @(posedge clock);
        check(32'(host.acks), 32'h1, "setup ack");
        rd_chk(REG_IFG, 32'h1, "setup flag");
        check(32'(irq), 32'h1, "irq");
        for (int i = 0; i < 8; i++) rd_chk(8'h20 + 8'(4 * i), 32'(sb[i]), "setup byte");
        wr_reg(REG_IE, 32'h0);
        repeat (2) @(posedge clock);
        check(32'(irq), 32'h0, "irq masked");
        wr_reg(REG_IE, 32'h7);
        wr_reg(8'h40, 32'hA5);
        wr_reg(8'h44, 32'h5A);
        wr_reg(REG_IN_CNT, 32'h82);
        host.token(TOK_IN, 4'h0);
        repeat (2) @(posedge clock);
        check(32'(host.naks), 32'h1, "in nak");
        check(32'(host.got.size()), 32'h0, "no data");
        host.token(TOK_IN, 4'h1);
        ep_en(1'b0);
        host.token(TOK_IN, 4'h0);
        repeat (2) @(posedge clock);
        check(32'(host.naks), 32'h1, "orphan token");
        wr_reg(REG_IFG, 32'h1);
        ep_en(1'b1);
        rd_chk(REG_IFG, 32'h1, "gated clear");
        fork
            host.token(TOK_IN, 4'h0);
            begin
                @(posedge clock);
                wr_reg(REG_IFG, 32'h1);
                rd_chk(REG_STATUS, 32'h0D, "clear pending");
            end
        join
        repeat (12) @(posedge clock);
        rd_chk(REG_IFG, 32'h0, "flag cleared");
        check(32'(host.naks), 32'h2, "nak during token");
        host.slow = 1'b1;
        host.token(TOK_IN, 4'h0);
        wait_bytes(4);
        exp_q = '{8'hA5, 8'h5A};
        c = crc16(exp_q);
        exp_q.push_back(c[7:0]);
        exp_q.push_back(c[15:8]);
        repeat (3) @(posedge clock);
        check(32'(host.got.size()), 32'h4, "packet length");
        check(32'(host.lasts), 32'h1, "final marker");
        cmp_got();
        rd_chk(REG_IFG, 32'h2, "tx done");
        wr_reg(REG_IFG, 32'h2);
        for (int i = 0; i < 8; i++) wr_reg(8'h40 + 8'(4 * i), 32'(8'h10 + 8'(i)));
        wr_reg(REG_IN_CNT, 32'h88);
        host.suspend();
        repeat (2) @(posedge clock);
        rd_chk(REG_IFG, 32'h4, "suspend flag");
        wr_reg(REG_IFG, 32'h4);
        host.token(TOK_IN, 4'h0);
        wait_bytes(3);
        wr_reg(REG_CTRL, 32'h1);
        repeat (8) @(posedge clock);
        exp_q = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17};
        check(32'(host.got.size() < 8), 32'h1, "aborted length");
        check(32'(host.lasts), 32'h1, "no final after abort");
        check(32'(usb_pll_enable), 32'h0, "pll pin");
        cmp_got();
        rd_chk(REG_STATUS, 32'h01, "disarmed");
        wr_reg(REG_CTRL, 32'h0);
        repeat (2) @(posedge clock);
        rd_chk(REG_IE, 32'h0, "mask after disable");
        rd_chk(REG_IN_CFG, 32'h0, "config after disable");
        wr_reg(REG_CTRL, 32'h3);
        ep_en(1'b1);
        rd_chk(REG_IN_CFG, 32'h80, "config reinit");
        host.token(TOK_OUT, 4'h0);
        repeat (2) @(posedge clock);
        check(32'(host.acks), 32'h2, "out ack after reinit");
        give_verdict();
    end
endmodule

// ===== sim/usb_ep0_ctrl_monitor.sv
module usb_ep0_ctrl_monitor import usb_ep0_pkg::*; (
    input wire logic       clock,
    input wire logic       nrst,
    input wire logic       usb_pll_enable,
    input wire logic       tok_valid,
    input wire logic [1:0] tok_kind,
    input wire logic [3:0] tok_ep,
    input wire logic       rx_valid,
    input wire logic       hs_valid,
    input wire logic       hs_nak,
    input wire logic       tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic       tx_last,
    input wire logic       tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    hs_one_cycle_a: assert property (hs_valid |=> !hs_valid)
        else $error("handshake held longer than one cycle");
    nak_for_in_a: assert property (hs_valid && hs_nak |->
        $past(tok_valid) && $past(tok_kind) == TOK_IN)
        else $error("nak sent without an in token");
    nak_no_data_a: assert property (hs_valid && hs_nak |-> !tx_valid [*2])
        else $error("data sent alongside a nak");
    hs_has_cause_a: assert property (hs_valid |-> $past(tok_valid) || $past(rx_valid))
        else $error("handshake without a token or setup byte");
    other_ep_quiet_a: assert property (tok_valid && tok_ep != 4'h0 && !rx_valid |=>
        !hs_valid)
        else $error("answer to a token for another endpoint");
    // an abort drops tx_valid a cycle after usb_pll_enable falls, so a drop after pll-off is allowed
    tx_hold_a: assert property (tx_valid && !tx_ready |=>
        !usb_pll_enable || (tx_valid && $stable(tx_data) && $stable(tx_last)))
        else $error("transmit byte changed before acceptance");
    last_then_idle_a: assert property (tx_valid && tx_ready && tx_last |=> !tx_valid)
        else $error("transmit continued after final byte");
    last_has_valid_a: assert property (tx_last |-> tx_valid)
        else $error("final marker without valid byte");
    pll_off_quiet_a: assert property (!usb_pll_enable |=> !tx_valid [*2])
        else $error("transmit active with pll disabled");

    setup_ack_c: cover property (hs_valid && !hs_nak);
    in_nak_c: cover property (hs_valid && hs_nak);
    stall_c: cover property (tx_valid && !tx_ready);
    last_c: cover property (tx_valid && tx_ready && tx_last);
endmodule

bind usb_ep0_ctrl usb_ep0_ctrl_monitor i_mon (
    .clock,
    .nrst,
    .usb_pll_enable,
    .tok_valid,
    .tok_kind,
    .tok_ep,
    .rx_valid,
    .hs_valid,
    .hs_nak,
    .tx_valid,
    .tx_data,
    .tx_last,
    .tx_ready
);

// ===== sim/usb_host_model.sv
module usb_host_model (
    input  wire logic       clock,
    output logic            tok_valid,
    output logic [1:0]      tok_kind,
    output logic [3:0]      tok_ep,
    output logic            tok_busy,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            suspend_det,
    output logic            tx_ready,
    input  wire logic       hs_valid,
    input  wire logic       hs_nak,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       slow;
    logic [3:0] cyc;
    logic [7:0] got[$];
    int         acks;
    int         naks;
    int         lasts;

    initial begin
        {tok_valid, tok_kind, tok_ep, tok_busy, rx_valid, rx_data, suspend_det} = '0;
        {slow, cyc} = '0;
        acks = 0;
        lasts = 0;
        naks = 0;
        tx_ready = 1'b1;
    end

    // slow mode stalls two cycles of four to exercise byte holding
    always @(posedge clock) begin
        cyc <= cyc + 4'h1;
        tx_ready <= !slow || cyc[1];
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        if (tx_valid && tx_ready && tx_last) begin
            lasts <= lasts + 1;
        end
        if (hs_valid) begin
            if (hs_nak) begin
                naks <= naks + 1;
            end else begin
                acks <= acks + 1;
            end
        end
    end

    // never waits for an answer: a silent device leaves an orphan token
    task automatic token(input logic [1:0] k, input logic [3:0] ep);
        tok_busy <= 1'b1;
        repeat (4) @(posedge clock);
        tok_busy <= 1'b0;
        tok_valid <= 1'b1;
        tok_kind <= k;
        tok_ep <= ep;
        @(posedge clock);
        tok_valid <= 1'b0;
        tok_kind <= ~k;
        tok_ep <= ~ep;
    endtask

    task automatic setup(input logic [7:0] b[8]);
        token(2'h2, 4'h0);
        for (int i = 0; i < 8; i++) begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            @(posedge clock);
        end
        rx_valid <= 1'b0;
        rx_data <= ~b[7];
    endtask

    task automatic suspend();
        suspend_det <= 1'b1;
        @(posedge clock);
        suspend_det <= 1'b0;
    endtask
endmodule

// ===== src/crc_feed_if.sv
interface crc_feed_if;
    logic        clear;
    logic        valid;
    logic [7:0]  data;
    logic [15:0] crc;

    modport gen (
        input  clear,
        input  valid,
        input  data,
        output crc
    );
    modport user (
        output clear,
        output valid,
        output data,
        input  crc
    );
endinterface

// ===== src/usb_data_crc.sv
module usb_data_crc (
    input wire logic clock,
    input wire logic nrst,
    crc_feed_if.gen  feed
);
    import usb_ep0_pkg::*;

    logic [15:0] state;
    logic [15:0] next_state;

    always_comb begin
        next_state = state ^ {8'h00, feed.data};
        for (int i = 0; i < 8; i++) begin
            next_state = next_state[0] ? ((next_state >> 1) ^ CRC_POLY) : (next_state >> 1);
        end
    end

    // only bytes the host really accepted are folded in
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state <= CRC_INIT;
        end else if (feed.clear) begin
            state <= CRC_INIT;
        end else if (feed.valid) begin
            state <= next_state;
        end
    end

    assign feed.crc = ~state;
endmodule

// ===== src/usb_ep0_ctrl.sv
// Local design decisions: the address-and-strobe port and the address map.
module usb_ep0_ctrl (
    input  wire logic                       clock,
    input  wire logic                       nrst,
    input  wire logic [usb_ep0_pkg::ADDR_W-1:0] addr,
    input  wire logic [usb_ep0_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [usb_ep0_pkg::DATA_W-1:0] rdata,
    output logic                            irq,
    output logic                            usb_pll_enable,
    input  wire logic                       tok_valid,
    input  wire logic [1:0]                 tok_kind,
    input  wire logic [3:0]                 tok_ep,
    input  wire logic                       tok_busy,
    input  wire logic                       rx_valid,
    input  wire logic [7:0]                 rx_data,
    input  wire logic                       suspend_det,
    output logic                            hs_valid,
    output logic                            hs_nak,
    output logic                            tx_valid,
    output logic [7:0]                      tx_data,
    output logic                            tx_last,
    input  wire logic                       tx_ready
);
    import usb_ep0_pkg::*;

    logic             usb_module_enable_bit;
    logic [IFG_W-1:0] usb_interrupt_flags;
    logic [IFG_W-1:0] ie;
    logic [7:0]       in_endpoint0_config;
    logic [7:0]       out_endpoint0_config;
    logic [3:0]       in_cnt;
    logic             in_armed;
    logic [7:0]       setup_buf [PKT_MAX];
    logic [7:0]       in_buf [PKT_MAX];
    logic [3:0]       setup_idx;
    logic             setup_rx;
    logic [3:0]       guard;
    logic             clear_pending;
    tx_state_t        tx_state;
    logic [3:0]       tx_idx;

    logic             endpoint_enable;
    logic             live;
    logic             ep0_tok;
    logic             sw_clear;
    logic             apply_clear;
    logic             setup_set;
    logic             setup_start;
    logic             in_nak;
    logic             tx_start;
    logic             tx_accept;
    logic             tx_done;
    logic             tx_abort;
    logic [2:0]       buf_idx;

    crc_feed_if crc_feed ();

    usb_data_crc u_crc (
        .clock (clock),
        .nrst  (nrst),
        .feed  (crc_feed)
    );

    assign endpoint_enable = in_endpoint0_config[EP_ENABLE_BIT]
                           & out_endpoint0_config[EP_ENABLE_BIT];
    assign live        = usb_module_enable_bit & usb_pll_enable;
    assign ep0_tok     = tok_valid && tok_ep == 4'h0 && live && endpoint_enable;
    assign setup_start = ep0_tok && tok_kind == TOK_SETUP;
    assign setup_set   = setup_rx && rx_valid && setup_idx == 4'(PKT_MAX - 1);
    // nak while the flag stands or nothing is armed; an in during a send is dropped
    assign in_nak      = ep0_tok && tok_kind == TOK_IN && tx_state == TX_IDLE
                       && (usb_interrupt_flags[IFG_SETUP] || !in_armed);
    assign tx_start    = ep0_tok && tok_kind == TOK_IN && tx_state == TX_IDLE
                       && !usb_interrupt_flags[IFG_SETUP] && in_armed;
    assign tx_accept   = tx_valid && tx_ready;
    assign tx_done     = tx_state == TX_CRC_HI && tx_accept;
    assign tx_abort    = tx_state != TX_IDLE && !usb_pll_enable;
    assign buf_idx     = addr[4:2];

    assign sw_clear    = wr && addr == REG_IFG && wdata[IFG_SETUP] && endpoint_enable;
    // the clear waits out the token plus one crc-bit time so a decision is never split
    assign apply_clear = (clear_pending || sw_clear) && !tok_busy && guard == 4'h0;

    assign crc_feed.clear = tx_start;
    assign crc_feed.valid = tx_state == TX_DATA && tx_accept;
    assign crc_feed.data  = tx_data;

    // control register survives a module disable so software can re-enable
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            usb_module_enable_bit <= CTRL_RESET[CTRL_MODULE_EN];
            usb_pll_enable        <= CTRL_RESET[CTRL_PLL_EN];
        end else if (wr && addr == REG_CTRL) begin
            usb_module_enable_bit <= wdata[CTRL_MODULE_EN];
            usb_pll_enable        <= wdata[CTRL_PLL_EN];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ie                   <= IE_RESET;
            in_endpoint0_config  <= 8'h00;
            out_endpoint0_config <= 8'h00;
            in_cnt               <= CNT_RESET;
        end else if (!usb_module_enable_bit) begin
            ie                   <= IE_RESET;
            in_endpoint0_config  <= 8'h00;
            out_endpoint0_config <= 8'h00;
            in_cnt               <= CNT_RESET;
        end else if (wr) begin
            case (addr)
                REG_IE:      ie <= wdata[IFG_W-1:0];
                REG_IN_CFG:  in_endpoint0_config <= wdata[7:0];
                REG_OUT_CFG: out_endpoint0_config <= wdata[7:0];
                REG_IN_CNT:  in_cnt <= (wdata[3:0] > 4'(PKT_MAX)) ? 4'(PKT_MAX) : wdata[3:0];
                default:     ;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (wr && addr[7:5] == IN_BUF_WIN) begin
            in_buf[buf_idx] <= wdata[7:0];
        end
        if (setup_rx && rx_valid) begin
            setup_buf[setup_idx[2:0]] <= rx_data;
        end
    end

    // set wins over a same-cycle clear on every flag
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            usb_interrupt_flags <= IFG_RESET;
        end else if (!usb_module_enable_bit) begin
            usb_interrupt_flags <= IFG_RESET;
        end else begin
            if (setup_set) begin
                usb_interrupt_flags[IFG_SETUP] <= 1'b1;
            end else if (apply_clear) begin
                usb_interrupt_flags[IFG_SETUP] <= 1'b0;
            end
            if (tx_done) begin
                usb_interrupt_flags[IFG_TX_DONE] <= 1'b1;
            end else if (wr && addr == REG_IFG && wdata[IFG_TX_DONE]) begin
                usb_interrupt_flags[IFG_TX_DONE] <= 1'b0;
            end
            if (suspend_det) begin
                usb_interrupt_flags[IFG_SUSPEND] <= 1'b1;
            end else if (wr && addr == REG_IFG && wdata[IFG_SUSPEND]) begin
                usb_interrupt_flags[IFG_SUSPEND] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            clear_pending <= 1'b0;
            guard         <= 4'h0;
        end else if (!usb_module_enable_bit) begin
            clear_pending <= 1'b0;
            guard         <= 4'h0;
        end else begin
            if (tok_busy) begin
                guard <= CRC_BIT_CYC;
            end else if (guard != 4'h0) begin
                guard <= guard - 4'h1;
            end
            if (setup_set || apply_clear) begin
                clear_pending <= 1'b0;
            end else if (sw_clear) begin
                clear_pending <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            setup_rx  <= 1'b0;
            setup_idx <= 4'h0;
        end else if (!live) begin
            setup_rx  <= 1'b0;
            setup_idx <= 4'h0;
        end else if (setup_start) begin
            setup_rx  <= 1'b1;
            setup_idx <= 4'h0;
        end else if (setup_rx && rx_valid) begin
            setup_idx <= setup_idx + 4'h1;
            setup_rx  <= !setup_set;
        end
    end

    // handshake: ack closes a setup or out, nak answers an unready in
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            hs_valid <= 1'b0;
            hs_nak   <= 1'b0;
        end else begin
            hs_valid <= setup_set || in_nak || (ep0_tok && tok_kind == TOK_OUT);
            hs_nak   <= in_nak;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            in_armed <= 1'b0;
        end else if (!usb_module_enable_bit || setup_start || tx_done || tx_abort) begin
            in_armed <= 1'b0;
        end else if (wr && addr == REG_IN_CNT) begin
            in_armed <= wdata[IN_CNT_ARMED];
        end
    end

    // byte index moves on acceptance and an abort resets it, so a re-armed send restarts from in_buf[0]
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            tx_state <= TX_IDLE;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
            tx_idx   <= 4'h0;
        end else if (!usb_module_enable_bit || tx_abort) begin
            tx_state <= TX_IDLE;
            tx_valid <= 1'b0;
            tx_last  <= 1'b0;
            tx_idx   <= 4'h0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_start) begin
                        tx_idx   <= 4'h1;
                        tx_data  <= in_buf[0];
                        tx_valid <= in_cnt != 4'h0;
                        tx_state <= (in_cnt != 4'h0) ? TX_DATA : TX_CRC_LO;
                    end
                end
                TX_DATA: begin
                    if (tx_accept) begin
                        if (tx_idx >= in_cnt) begin
                            tx_valid <= 1'b0;
                            tx_state <= TX_CRC_LO;
                        end else begin
                            tx_data <= in_buf[tx_idx[2:0]];
                            tx_idx  <= tx_idx + 4'h1;
                        end
                    end
                end
                TX_CRC_LO: begin
                    if (!tx_valid) begin
                        tx_valid <= 1'b1;
                        tx_data  <= crc_feed.crc[7:0];
                    end else if (tx_accept) begin
                        tx_data  <= crc_feed.crc[15:8];
                        tx_last  <= 1'b1;
                        tx_state <= TX_CRC_HI;
                    end
                end
                TX_CRC_HI: begin
                    if (tx_accept) begin
                        tx_valid <= 1'b0;
                        tx_last  <= 1'b0;
                        tx_state <= TX_IDLE;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                    tx_valid <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(usb_interrupt_flags & ie);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (rd) begin
            rdata <= '0;
            if (addr[7:5] == SETUP_WIN) begin
                rdata[7:0] <= setup_buf[buf_idx];
            end else begin
                case (addr)
                    REG_CTRL:    rdata[1:0] <= {usb_pll_enable, usb_module_enable_bit};
                    REG_IFG:     rdata[IFG_W-1:0] <= usb_interrupt_flags;
                    REG_IE:      rdata[IFG_W-1:0] <= ie;
                    REG_IN_CFG:  rdata[7:0] <= in_endpoint0_config;
                    REG_OUT_CFG: rdata[7:0] <= out_endpoint0_config;
                    REG_IN_CNT:  rdata[7:0] <= {in_armed, 3'h0, in_cnt};
                    REG_STATUS:  rdata[4:0] <= {tx_state != TX_IDLE, clear_pending,
                                                in_armed, setup_rx, endpoint_enable};
                    default:     ;
                endcase
            end
        end
    end
endmodule

// ===== src/usb_ep0_pkg.sv
package usb_ep0_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] REG_IFG      = 8'h04;
    localparam logic [ADDR_W-1:0] REG_IE       = 8'h08;
    localparam logic [ADDR_W-1:0] REG_IN_CFG   = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_OUT_CFG  = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IN_CNT   = 8'h14;
    localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h18;
    localparam logic [2:0]        SETUP_WIN    = 3'h1;
    localparam logic [2:0]        IN_BUF_WIN   = 3'h2;

    localparam int CTRL_MODULE_EN  = 0;
    localparam int CTRL_PLL_EN     = 1;
    localparam int IFG_SETUP       = 0;
    localparam int IFG_TX_DONE     = 1;
    localparam int IFG_SUSPEND     = 2;
    localparam int IFG_W           = 3;
    localparam int EP_ENABLE_BIT   = 7;
    localparam int IN_CNT_ARMED    = 7;
    localparam int PKT_MAX         = 8;

    localparam logic [1:0]       CTRL_RESET = 2'h0;
    localparam logic [IFG_W-1:0] IFG_RESET  = 3'h0;
    localparam logic [IFG_W-1:0] IE_RESET   = 3'h0;
    localparam logic [3:0]       CNT_RESET  = 4'h0;

    localparam logic [1:0] TOK_OUT   = 2'h0;
    localparam logic [1:0] TOK_IN    = 2'h1;
    localparam logic [1:0] TOK_SETUP = 2'h2;
    localparam logic [1:0] TOK_SOF   = 2'h3;

    localparam int CLK_PERIOD_NS  = 10;
    localparam int CRC_BIT_NS     = 83;
    localparam int CRC_BIT_CYC_I  = (CRC_BIT_NS / CLK_PERIOD_NS) < 1 ? 1
                                    : CRC_BIT_NS / CLK_PERIOD_NS;
    localparam logic [3:0] CRC_BIT_CYC = 4'(CRC_BIT_CYC_I);

    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_DATA,
        TX_CRC_LO,
        TX_CRC_HI
    } tx_state_t;
endpackage
